// ### sci_cpu_model.sv
module sci_cpu_model (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic fast_i,
   input wire logic normal_i,
   output int fast_cnt_o,
   output int normal_cnt_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic fast_d;
   logic normal_d;
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         fast_d <= 1'b0;
         normal_d <= 1'b0;
         fast_cnt_o <= 0;
         normal_cnt_o <= 0;
      end else begin
         fast_d <= fast_i;
         normal_d <= normal_i;
         if (fast_i && !fast_d) begin
            fast_cnt_o <= fast_cnt_o + 1;
         end else if (normal_i && !normal_d) begin
            normal_cnt_o <= normal_cnt_o + 1;
         end
      end
   end
endmodule : sci_cpu_model

// ### sci_pkg.sv
package sci_pkg;
   localparam int unsigned GPIO_W = 28;
   localparam int unsigned NMATCH = 4;
   localparam int unsigned WDOG_IDX = 3;
   localparam int unsigned NPER = 6;
   localparam int unsigned NSRC = 8;
   localparam int unsigned SRC_TMR = 0;
   localparam int unsigned SRC_GPIO = 1;
   localparam int unsigned SRC_PER = 2;
   localparam int unsigned NUNIT = 4;

   // Register byte addresses
   localparam logic [7:0] A_COUNT = 8'h00;
   localparam logic [7:0] A_MATCH0 = 8'h04;
   localparam logic [7:0] A_MATCH_STEP = 8'h04;
   localparam logic [7:0] A_TMR_STAT = 8'h14;
   localparam logic [7:0] A_TMR_CLR = 8'h18;
   localparam logic [7:0] A_TMR_EN = 8'h1c;
   localparam logic [7:0] A_WDOG_EN = 8'h20;
   localparam logic [7:0] A_GPIO_LEVEL = 8'h24;
   localparam logic [7:0] A_GPIO_OUT = 8'h28;
   localparam logic [7:0] A_GPIO_DIR = 8'h2c;
   localparam logic [7:0] A_GPIO_RISE = 8'h30;
   localparam logic [7:0] A_GPIO_FALL = 8'h34;
   localparam logic [7:0] A_GPIO_STAT = 8'h38;
   localparam logic [7:0] A_GPIO_CLR = 8'h3c;
   localparam logic [7:0] A_GPIO_EN = 8'h40;
   localparam logic [7:0] A_GPIO_ALT = 8'h44;
   localparam logic [7:0] A_INT_PEND = 8'h48;
   localparam logic [7:0] A_INT_LEVEL = 8'h4c;
   localparam logic [7:0] A_INT_MASK = 8'h50;
   localparam logic [7:0] A_RST_CAUSE = 8'h54;
   localparam logic [7:0] A_RST_SOFT = 8'h58;
   localparam logic [7:0] A_PWR_CTRL = 8'h5c;

   // Field positions
   localparam int unsigned WDOG_EN_BIT = 0;
   localparam int unsigned SOFT_RST_BIT = 0;
   localparam int unsigned PWR_IDLE_BIT = 0;
   localparam int unsigned PWR_SLEEP_BIT = 1;
   localparam int unsigned PWR_OSC_BIT = 2;
   localparam int unsigned PWR_MODE_LSB = 4;

   // Reset cause values, one hot
   localparam logic [3:0] RC_HARD = 4'h1;
   localparam logic [3:0] RC_SOFT = 4'h2;
   localparam logic [3:0] RC_WDOG = 4'h4;
   localparam logic [3:0] RC_SLEEP = 4'h8;

   // Timing
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned WAKE_FAST_MS = 10;
   localparam int unsigned WAKE_SLOW_MS = 160;
   localparam int unsigned WAKE_FAST_CYC = WAKE_FAST_MS * CLK_MHZ * 1000;
   localparam int unsigned WAKE_SLOW_CYC = WAKE_SLOW_MS * CLK_MHZ * 1000;

   typedef enum logic [2:0] {
      PWR_NORMAL = 3'b000,
      PWR_IDLE = 3'b001,
      PWR_SR_WAIT = 3'b010,
      PWR_SLEEP = 3'b011,
      PWR_WAKE = 3'b100
   } sci_pwr_t;
endpackage : sci_pkg

// ### sci_sync_edge.sv
module sci_sync_edge #(
   parameter int unsigned W = 8
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] level_o,
   output logic [W-1:0] rise_o,
   output logic [W-1:0] fall_o
);
   import sci_pkg::*;

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
   } sci_sync_t;

   sci_sync_t st_ff;
   sci_sync_t nxt_st;

   // First stage feeds only the second
   always_comb begin
      nxt_st.s1 = d_i;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         st_ff <= '0;
      end else if (ce_i) begin
         st_ff <= nxt_st;
      end
   end

   assign level_o = st_ff.s2;
   assign rise_o = st_ff.s2 & ~st_ff.s3;
   assign fall_o = ~st_ff.s2 & st_ff.s3;
endmodule : sci_sync_edge

// ### sci_top.sv
// Implementation choices: strobed register access and the address map.
module sci_top #(
   parameter int unsigned WAKE_FAST = sci_pkg::WAKE_FAST_CYC,
   parameter int unsigned WAKE_SLOW = sci_pkg::WAKE_SLOW_CYC
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   input wire logic osc_tick_i,
   input wire logic [sci_pkg::GPIO_W-1:0] gpio_in_i,
   output logic [sci_pkg::GPIO_W-1:0] gpio_out_o,
   output logic [sci_pkg::GPIO_W-1:0] gpio_oe_o,
   output logic [sci_pkg::GPIO_W-1:0] gpio_alt_o,
   input wire logic [sci_pkg::NPER-1:0] periph_irq_i,
   input wire logic [sci_pkg::NUNIT-1:0] unit_busy_i,
   input wire logic dram_sr_ack_i,
   output logic fast_interrupt_request_o,
   output logic normal_interrupt_request_o,
   output logic int_o,
   output logic cpu_clk_en_o,
   output logic [sci_pkg::NUNIT-1:0] unit_clk_en_o,
   output logic dram_sr_req_o,
   output logic sleep_o,
   output logic sys_reset_o
);
   import sci_pkg::*;

   localparam int unsigned SW = GPIO_W + 2;
   localparam int unsigned OSC_IDX = GPIO_W;
   localparam int unsigned ACK_IDX = GPIO_W + 1;

   typedef struct packed {
      logic [31:0] count;
      logic [NMATCH-1:0][31:0] match;
      logic [NMATCH-1:0] tstat;
      logic [NMATCH-1:0] ten;
      logic wden;
      logic [GPIO_W-1:0] gout;
      logic [GPIO_W-1:0] gdir;
      logic [GPIO_W-1:0] grise;
      logic [GPIO_W-1:0] gfall;
      logic [GPIO_W-1:0] gstat;
      logic [GPIO_W-1:0] gen;
      logic [GPIO_W-1:0] galt;
      logic [GPIO_W-1:0] goe;
      logic [NSRC-1:0] ilevel;
      logic [NSRC-1:0] imask;
      logic [3:0] cause;
      sci_pwr_t mode;
      logic oscsel;
      logic [31:0] wcnt;
      logic srreq;
      logic sleep;
      logic cpuen;
      logic [NUNIT-1:0] uclk;
      logic fast_interrupt_request;
      logic irq;
      logic intr;
      logic sysrst;
      logic [31:0] rdata;
   } sci_state_t;

   sci_state_t st_ff;
   sci_state_t nxt_st;

   logic [SW-1:0] s_lvl;
   logic [SW-1:0] s_rise;
   logic [SW-1:0] s_fall;
   logic tick;
   logic [NMATCH-1:0] mhit;
   logic [NMATCH-1:0] msel;
   logic [NMATCH-1:0] tclr;
   logic [GPIO_W-1:0] gset;
   logic [GPIO_W-1:0] gclr;
   logic [NSRC-1:0] pend;
   logic [NSRC-1:0] pend_en;
   logic req_idle;
   logic req_sleep;
   logic soft_rst;
   logic do_rst;
   logic [3:0] rcause;
   logic [31:0] rd;

   function automatic logic [NMATCH-1:0] match_sel(input logic [7:0] a);
      logic [NMATCH-1:0] s;
      s = '0;
      for (int i = 0; i < NMATCH; i++) begin
         if (a == A_MATCH0 + A_MATCH_STEP * 8'(i)) begin
            s[i] = 1'b1;
         end
      end
      return s;
   endfunction : match_sel

   // Set beats a clear arriving in the same cycle
   function automatic logic [31:0] sticky(input logic [31:0] old,
                                          input logic [31:0] clr,
                                          input logic [31:0] set);
      return (old & ~clr) | set;
   endfunction : sticky

   // Oscillator tick, pins and DRAM ack all come from outside
   sci_sync_edge #(
      .W(SW)
   ) u_sync (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .d_i({dram_sr_ack_i, osc_tick_i, gpio_in_i}),
      .level_o(s_lvl),
      .rise_o(s_rise),
      .fall_o(s_fall)
   );

   always_comb begin
      nxt_st = st_ff;
      nxt_st.sysrst = 1'b0;
      tclr = '0;
      gclr = '0;
      req_idle = 1'b0;
      req_sleep = 1'b0;
      soft_rst = 1'b0;
      do_rst = 1'b0;
      rcause = RC_HARD;
      rd = '0;
      msel = match_sel(reg_addr_i);

      tick = s_rise[OSC_IDX] &&
             (st_ff.mode == PWR_NORMAL || st_ff.mode == PWR_IDLE);
      if (tick) begin
         nxt_st.count = st_ff.count + 32'h1;
      end
      for (int i = 0; i < NMATCH; i++) begin
         mhit[i] = tick && (st_ff.count + 32'h1 == st_ff.match[i]);
      end

      gset = ((s_rise[GPIO_W-1:0] & st_ff.grise) |
              (s_fall[GPIO_W-1:0] & st_ff.gfall)) & ~st_ff.galt;

      if (reg_wr_i) begin
         case (reg_addr_i)
            A_COUNT: nxt_st.count = reg_wdata_i;
            A_TMR_CLR: tclr = reg_wdata_i[NMATCH-1:0];
            A_TMR_EN: nxt_st.ten = reg_wdata_i[NMATCH-1:0];
            // Only a reset disarms it, so runaway code cannot
            A_WDOG_EN: begin
               if (reg_wdata_i[WDOG_EN_BIT]) begin
                  nxt_st.wden = 1'b1;
               end
            end
            A_GPIO_OUT: nxt_st.gout = reg_wdata_i[GPIO_W-1:0];
            A_GPIO_DIR: nxt_st.gdir = reg_wdata_i[GPIO_W-1:0];
            A_GPIO_RISE: nxt_st.grise = reg_wdata_i[GPIO_W-1:0];
            A_GPIO_FALL: nxt_st.gfall = reg_wdata_i[GPIO_W-1:0];
            A_GPIO_CLR: gclr = reg_wdata_i[GPIO_W-1:0];
            A_GPIO_EN: nxt_st.gen = reg_wdata_i[GPIO_W-1:0];
            A_GPIO_ALT: nxt_st.galt = reg_wdata_i[GPIO_W-1:0];
            A_INT_LEVEL: nxt_st.ilevel = reg_wdata_i[NSRC-1:0];
            A_INT_MASK: nxt_st.imask = reg_wdata_i[NSRC-1:0];
            A_RST_SOFT: soft_rst = reg_wdata_i[SOFT_RST_BIT];
            A_PWR_CTRL: begin
               nxt_st.oscsel = reg_wdata_i[PWR_OSC_BIT];
               req_idle = reg_wdata_i[PWR_IDLE_BIT];
               req_sleep = reg_wdata_i[PWR_SLEEP_BIT];
            end
            default: ;
         endcase
         for (int i = 0; i < NMATCH; i++) begin
            if (msel[i]) begin
               nxt_st.match[i] = reg_wdata_i;
            end
         end
      end

      nxt_st.tstat = NMATCH'(sticky(32'(st_ff.tstat), 32'(tclr),
                                    32'(mhit)));
      nxt_st.gstat = GPIO_W'(sticky(32'(st_ff.gstat), 32'(gclr),
                                    32'(gset)));

      pend = '0;
      pend[SRC_TMR] = |(st_ff.tstat & st_ff.ten);
      pend[SRC_GPIO] = |(st_ff.gstat & st_ff.gen);
      pend[SRC_PER +: NPER] = periph_irq_i;
      pend_en = pend & st_ff.imask;

      // fast has its own line to preempt
      nxt_st.fast_interrupt_request = |(pend_en & st_ff.ilevel);
      nxt_st.irq = |(pend_en & ~st_ff.ilevel);
      nxt_st.intr = |pend_en;

      // normal, idle, sleep plus transit states
      unique case (st_ff.mode)
         PWR_NORMAL: begin
            if (req_sleep) begin
               nxt_st.mode = PWR_SR_WAIT;
            end else if (req_idle) begin
               nxt_st.mode = PWR_IDLE;
            end
         end
         PWR_IDLE: begin
            if (|pend_en) begin
               nxt_st.mode = PWR_NORMAL;
            end
         end
         PWR_SR_WAIT: begin
            if (s_lvl[ACK_IDX]) begin
               nxt_st.mode = PWR_SLEEP;
            end
         end
         PWR_SLEEP: begin
            if (|pend_en) begin
               nxt_st.mode = PWR_WAKE;
               nxt_st.wcnt = st_ff.oscsel ? WAKE_FAST - 1 :
                                            WAKE_SLOW - 1;
            end
         end
         PWR_WAKE: begin
            if (st_ff.wcnt == 32'h0) begin
               do_rst = 1'b1;
               rcause = RC_SLEEP;
            end else begin
               nxt_st.wcnt = st_ff.wcnt - 32'h1;
            end
         end
         default: nxt_st.mode = PWR_NORMAL;
      endcase

      nxt_st.cpuen = nxt_st.mode == PWR_NORMAL;
      nxt_st.uclk = (nxt_st.mode == PWR_NORMAL ||
                     nxt_st.mode == PWR_IDLE) ? unit_busy_i : '0;
      // hold self-refresh until reset on wake
      nxt_st.srreq = nxt_st.mode == PWR_SR_WAIT ||
                     nxt_st.mode == PWR_SLEEP ||
                     nxt_st.mode == PWR_WAKE;
      nxt_st.sleep = nxt_st.mode == PWR_SLEEP;
      // Pins lent to an alternate function are driven by that unit
      nxt_st.goe = nxt_st.gdir & ~nxt_st.galt;

      if (reg_rd_i) begin
         case (reg_addr_i)
            A_COUNT: rd = st_ff.count;
            A_TMR_STAT: rd = 32'(st_ff.tstat);
            A_TMR_EN: rd = 32'(st_ff.ten);
            A_WDOG_EN: rd = 32'(st_ff.wden);
            A_GPIO_LEVEL: rd = 32'(s_lvl[GPIO_W-1:0]);
            A_GPIO_OUT: rd = 32'(st_ff.gout);
            A_GPIO_DIR: rd = 32'(st_ff.gdir);
            A_GPIO_RISE: rd = 32'(st_ff.grise);
            A_GPIO_FALL: rd = 32'(st_ff.gfall);
            A_GPIO_STAT: rd = 32'(st_ff.gstat);
            A_GPIO_EN: rd = 32'(st_ff.gen);
            A_GPIO_ALT: rd = 32'(st_ff.galt);
            A_INT_PEND: rd = 32'(pend);
            A_INT_LEVEL: rd = 32'(st_ff.ilevel);
            A_INT_MASK: rd = 32'(st_ff.imask);
            A_RST_CAUSE: rd = 32'(st_ff.cause);
            A_PWR_CTRL: begin
               rd[PWR_OSC_BIT] = st_ff.oscsel;
               rd[PWR_MODE_LSB +: 3] = st_ff.mode;
            end
            default: rd = '0;
         endcase
         for (int i = 0; i < NMATCH; i++) begin
            if (msel[i]) begin
               rd = st_ff.match[i];
            end
         end
      end
      nxt_st.rdata = rd;

      if (st_ff.wden && mhit[WDOG_IDX]) begin
         do_rst = 1'b1;
         rcause = RC_WDOG;
      end
      if (soft_rst) begin
         do_rst = 1'b1;
         rcause = RC_SOFT;
      end
      // internal reset, all state cleared to zero except cause, which records the source, and sysrst, which is set
      if (do_rst) begin
         nxt_st = '0;
         nxt_st.cause = rcause;
         nxt_st.sysrst = 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         st_ff <= '0;
         st_ff.cause <= RC_HARD;
      end else if (ce_i) begin
         st_ff <= nxt_st;
      end
   end

   assign reg_rdata_o = st_ff.rdata;
   assign gpio_out_o = st_ff.gout;
   assign gpio_oe_o = st_ff.goe;
   assign gpio_alt_o = st_ff.galt;
   assign fast_interrupt_request_o = st_ff.fast_interrupt_request;
   assign normal_interrupt_request_o = st_ff.irq;
   assign int_o = st_ff.intr;
   assign cpu_clk_en_o = st_ff.cpuen;
   assign unit_clk_en_o = st_ff.uclk;
   assign dram_sr_req_o = st_ff.srreq;
   assign sleep_o = st_ff.sleep;
   assign sys_reset_o = st_ff.sysrst;
endmodule : sci_top

// ### sci_top_sva.sv
module sci_top_sva (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic [sci_pkg::NUNIT-1:0] unit_busy_i,
   input wire logic [sci_pkg::GPIO_W-1:0] gpio_oe_o,
   input wire logic [sci_pkg::GPIO_W-1:0] gpio_alt_o,
   input wire logic fast_interrupt_request_o,
   input wire logic normal_interrupt_request_o,
   input wire logic int_o,
   input wire logic cpu_clk_en_o,
   input wire logic [sci_pkg::NUNIT-1:0] unit_clk_en_o,
   input wire logic dram_sr_req_o,
   input wire logic sleep_o,
   input wire logic sys_reset_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import sci_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);

   sequence soft_wr;
      ce_i && reg_wr_i && reg_addr_i == A_RST_SOFT && reg_wdata_i[0];
   endsequence
   sequence sleep_entry;
      $rose(sleep_o);
   endsequence

   a_rdata_idle: assert property ($past(ce_i) && !$past(reg_rd_i) |->
      reg_rdata_o == 32'h0) else $error("read data not idle");
   a_int_join: assert property (int_o ==
      (fast_interrupt_request_o || normal_interrupt_request_o))
      else $error("request lines disagree with summary");
   a_sleep_cpu: assert property (sleep_o |-> !cpu_clk_en_o)
      else $error("cpu clock on in sleep");
   a_sleep_units: assert property (sleep_o |-> unit_clk_en_o == '0)
      else $error("unit clock on in sleep");
   a_unit_clk: assert property (cpu_clk_en_o && $past(ce_i) &&
      !$past(sys_reset_o) |-> unit_clk_en_o == $past(unit_busy_i))
      else $error("unit clock does not follow busy");
   a_oe_alt: assert property ((gpio_oe_o & gpio_alt_o) == '0)
      else $error("alternate pin driven");
   a_rst_pulse: assert property (sys_reset_o && ce_i |=>
      !sys_reset_o && cpu_clk_en_o) else $error("reset pulse shape");
   a_soft_rst: assert property (soft_wr |-> ##[1:2] sys_reset_o)
      else $error("soft reset missing");
   a_sleep_seq: assert property (sleep_entry |->
      $past(dram_sr_req_o)) else $error("sleep before self refresh");
endmodule : sci_top_sva

bind sci_top sci_top_sva u_sva (.clk_i, .reset_i, .ce_i, .reg_addr_i,
   .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .unit_busy_i,
   .gpio_oe_o, .gpio_alt_o, .fast_interrupt_request_o,
   .normal_interrupt_request_o, .int_o, .cpu_clk_en_o, .unit_clk_en_o,
   .dram_sr_req_o, .sleep_o, .sys_reset_o);

// ### sci_top_tb_top.sv
module sci_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import sci_pkg::*;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic ce_i = 1'b1;
   logic [7:0] reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic osc_tick_i = 1'b0;
   logic [GPIO_W-1:0] gpio_in_i = '0;
   logic [NPER-1:0] periph_irq_i = '0;
   logic [NUNIT-1:0] unit_busy_i = '0;
   logic dram_sr_ack_i = 1'b0;
   logic [31:0] reg_rdata_o;
   logic [GPIO_W-1:0] gpio_out_o, gpio_oe_o, gpio_alt_o;
   logic fast_interrupt_request_o, normal_interrupt_request_o, int_o;
   logic cpu_clk_en_o, dram_sr_req_o, sleep_o, sys_reset_o;
   logic [NUNIT-1:0] unit_clk_en_o;
   logic [2:0] watch;
   int mismatches = 0;
   int n_compared = 0;
   int n_fast, n_norm;
   int osc_div = 0;

   sci_top #(.WAKE_FAST(8), .WAKE_SLOW(16)) DUT (.clk_i, .reset_i, .ce_i,
      .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
      .osc_tick_i, .gpio_in_i, .gpio_out_o, .gpio_oe_o, .gpio_alt_o,
      .periph_irq_i, .unit_busy_i, .dram_sr_ack_i,
      .fast_interrupt_request_o, .normal_interrupt_request_o, .int_o,
      .cpu_clk_en_o, .unit_clk_en_o, .dram_sr_req_o, .sleep_o,
      .sys_reset_o);
   sci_cpu_model u_cpu (.clk_i, .reset_i, .fast_i(fast_interrupt_request_o),
      .normal_i(normal_interrupt_request_o), .fast_cnt_o(n_fast),
      .normal_cnt_o(n_norm));
   assign watch = {cpu_clk_en_o, sleep_o, sys_reset_o};

   initial forever #4 clk_i = ~clk_i;
   // Slow tick near 3.7 MHz: 17 clocks per half period
   always @(posedge clk_i) begin
      osc_div <= (osc_div == 16) ? 0 : osc_div + 1;
      if (osc_div == 16) begin
         osc_tick_i <= ~osc_tick_i;
      end
   end
   // Memory enters self-refresh one cycle after the request
   always @(posedge clk_i) dram_sr_ack_i <= dram_sr_req_o;

   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1;
      chk(reg_rdata_o, e);
   endtask : rd

   task automatic wait_n(input int n);
      repeat (n) @(negedge clk_i);
   endtask : wait_n

   // Bounded poll of one watched output, then confirm it rose
   task automatic wait_hi(input int b);
      for (int i = 0; i < 300 && watch[b] !== 1'b1; i++) @(negedge clk_i);
      chk(32'(watch[b]), 32'h1);
   endtask : wait_hi

   task automatic pins(input logic [GPIO_W-1:0] v);
      @(posedge clk_i);
      gpio_in_i <= v;
      wait_n(8);
   endtask : pins

   initial begin
      #100us;
      mismatches++;
      finish_test();
   end

   initial begin
      repeat (4) @(posedge clk_i);
      reset_i <= 1'b0;
      wait_n(2);
      chk(32'(cpu_clk_en_o), 32'h1);
      rd(A_RST_CAUSE, 32'(RC_HARD));
      wr(A_GPIO_OUT, 32'hfabcdef1);
      rd(A_GPIO_OUT, 32'h0abcdef1);
      chk(32'(gpio_out_o), 32'h0abcdef1);
      rd(8'hfc, 32'h0);
      // Clock enable low: a write must not land
      @(posedge clk_i) ce_i <= 1'b0;
      wr(A_GPIO_OUT, 32'h3);
      ce_i <= 1'b1;
      rd(A_GPIO_OUT, 32'h0abcdef1);
      pins(28'h5a5a5a5);
      rd(A_GPIO_LEVEL, 32'h05a5a5a5);
      pins(28'h0);
      $display("test registers done");
      wr(A_GPIO_RISE, 32'h5);
      wr(A_GPIO_FALL, 32'h6);
      wr(A_GPIO_EN, 32'h7);
      wr(A_INT_MASK, 32'h6);
      pins(28'h7);
      rd(A_GPIO_STAT, 32'h5);
      chk(32'(normal_interrupt_request_o), 32'h1);
      pins(28'h0);
      rd(A_GPIO_STAT, 32'h7);
      rd(A_INT_PEND, 32'h2);
      wr(A_INT_LEVEL, 32'h2);
      wait_n(3);
      chk(32'(fast_interrupt_request_o), 32'h1);
      chk(32'(n_fast), 32'h1);
      wr(A_GPIO_CLR, 32'h7);
      wait_n(3);
      chk(32'(int_o), 32'h0);
      @(posedge clk_i);
      periph_irq_i <= 6'h01;
      wait_n(3);
      rd(A_INT_PEND, 32'h4);
      chk(32'(normal_interrupt_request_o), 32'h1);
      @(posedge clk_i) periph_irq_i <= 6'h00;
      $display("test interrupts done");
      wr(A_GPIO_DIR, 32'hff);
      wr(A_GPIO_ALT, 32'h1);
      unit_busy_i <= 4'ha;
      wait_n(3);
      chk(32'(gpio_oe_o), 32'hfe);
      chk(32'(gpio_alt_o), 32'h1);
      chk(32'(unit_clk_en_o), 32'ha);
      pins(28'h1);
      rd(A_GPIO_STAT, 32'h0);
      $display("test pins done");
      wr(A_TMR_EN, 32'h1);
      wr(A_INT_MASK, 32'h1);
      wr(A_MATCH0, 32'h5);
      wr(A_COUNT, 32'h0);
      wait_n(300);
      rd(A_TMR_STAT, 32'h1);
      rd(A_INT_PEND, 32'h1);
      chk(32'(int_o), 32'h1);
      wr(A_TMR_CLR, 32'h1);
      wr(A_INT_MASK, 32'h2);
      $display("test timer done");
      wr(A_PWR_CTRL, 32'h1);
      wait_n(2);
      chk(32'(cpu_clk_en_o), 32'h0);
      chk(32'(unit_clk_en_o), 32'ha);
      rd(A_PWR_CTRL, 32'h10);
      pins(28'h5);
      wait_hi(2);
      wr(A_GPIO_CLR, 32'h7);
      $display("test idle done");
      wr(A_PWR_CTRL, 32'h6);
      wait_hi(1);
      chk(32'(dram_sr_req_o), 32'h1);
      pins(28'h1);
      wait_hi(0);
      rd(A_RST_CAUSE, 32'(RC_SLEEP));
      $display("test sleep done");
      wr(A_RST_SOFT, 32'h1);
      wait_hi(0);
      rd(A_RST_CAUSE, 32'(RC_SOFT));
      wr(A_INT_MASK, 32'h4);
      wr(A_PWR_CTRL, 32'h2);
      wait_hi(1);
      @(posedge clk_i) periph_irq_i <= 6'h01;
      wait_n(10);
      rd(A_PWR_CTRL, 32'h40);
      wait_hi(0);
      rd(A_RST_CAUSE, 32'(RC_SLEEP));
      @(posedge clk_i) periph_irq_i <= 6'h00;
      wr(A_MATCH0 + 8'h3 * A_MATCH_STEP, 32'h4);
      wr(A_COUNT, 32'h0);
      wr(A_WDOG_EN, 32'h1);
      wait_hi(0);
      rd(A_RST_CAUSE, 32'(RC_WDOG));
      $display("test resets done");
      finish_test();
   end
endmodule : sci_top_tb_top
